/* File: rtl/olmr_pkg.sv */
// constants shared by the one-line mode routing host and its aux line shifter
package olmr_pkg;
  // device register offsets
  localparam logic [7:0] REG_SPEED_ROUTING = 8'h03;
  localparam logic [7:0] REG_SERIAL_FORMAT = 8'h04;
  localparam logic [7:0] REG_MASTER_CLKSEL = 8'h05;
  // speed_and_port_routing field positions
  localparam int CODEC_FM_POS = 6;
  localparam int IFACE_FM_POS = 4;
  localparam int CAPSEL_POS = 2;
  // serial_format_select field positions
  localparam int FMT_POS = 4;
  localparam int CAP_OL_POS = 2;
  localparam int PB_OL_POS = 0;
  // port_master_and_clock_select bit positions
  localparam int CODEC_MS_BIT = 7;
  localparam int IFACE_MS_BIT = 6;
  localparam int EXT_CLKSEL_BIT = 5;
  // speed-mode codes
  localparam logic [1:0] SPEED_SINGLE = 2'h0;
  localparam logic [1:0] SPEED_DOUBLE = 2'h1;
  localparam logic [1:0] SPEED_QUAD = 2'h2;
  // one-line mode codes
  localparam logic [1:0] OL_NONE = 2'h0;
  localparam logic [1:0] OL_ONE = 2'h1;
  localparam logic [1:0] OL_TWO = 2'h2;
  localparam logic [1:0] OL_RESVD = 2'h3;
  // capture port select codes
  localparam logic [1:0] CAPSEL_CODEC = 2'h0;
  localparam logic [1:0] CAPSEL_IFACE = 2'h2;
  // external converter clock select values and the port master bit value
  localparam logic CLKSEL_CODEC = 1'b1;
  localparam logic CLKSEL_IFACE = 1'b0;
  localparam logic MASTER = 1'b1;
  // aux line sample format
  localparam int SAMPLE_BITS = 24;
  localparam logic [4:0] LAST_BIT_CNT = 5'h17;
  localparam logic LEFT_LEVEL = 1'b1;
  localparam int AUX_LINES = 2;
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WR_MODE = 5'b00010,
    ST_WR_FMT = 5'b00100,
    ST_WR_MISC = 5'b01000,
    ST_RUN = 5'b10000
  } olmr_state_t;
endpackage

/* File: rtl/olmr_aux_shifter.sv */
// one aux converter line: left-justified 24-bit stereo word, msb first
`timescale 1ns/100ps
module olmr_aux_shifter
  import olmr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic bit_fall, // one cycle after a bit clock falling edge
  input wire logic frame_level, // synchronised frame clock level
  input wire logic active, // aux line in use
  input wire logic [47:0] word, // {left, right} sample pair
  output logic line, // serial data to the device
  output logic take // pulse: word consumed at left half start
);
  logic prev_lr;
  logic next_prev_lr;
  logic [23:0] shift;
  logic [23:0] next_shift;
  logic [23:0] held;
  logic [23:0] next_held;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic next_line;
  logic new_half;
  logic [23:0] src;

  assign new_half = bit_fall && (frame_level != prev_lr);

  always_comb begin
    next_prev_lr = prev_lr;
    next_shift = shift;
    next_held = held;
    next_cnt = cnt;
    next_line = line;
    take = 1'b0;
    src = held;
    if (!active) begin
      next_line = 1'b0;
      next_cnt = '0;
      next_prev_lr = frame_level;
    end else if (new_half) begin
      // data moves on the falling edge so it is stable at the device's rising edge
      next_prev_lr = frame_level;
      if (frame_level == LEFT_LEVEL) begin
        src = word[47:24];
        next_held = word[23:0];
        take = 1'b1;
      end
      next_line = src[SAMPLE_BITS-1];
      next_shift = {src[22:0], 1'b0};
      next_cnt = LAST_BIT_CNT;
    end else if (bit_fall) begin
      if (cnt != '0) begin
        next_line = shift[SAMPLE_BITS-1];
        next_shift = {shift[22:0], 1'b0};
        next_cnt = cnt - 5'h1;
      end else begin
        // 64Fs and 128Fs frames both just pad zeros after bit 24
        next_line = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_lr <= 1'b0;
      shift <= '0;
      held <= '0;
      cnt <= '0;
      line <= 1'b0;
    end else begin
      prev_lr <= next_prev_lr;
      shift <= next_shift;
      held <= next_held;
      cnt <= next_cnt;
      line <= next_line;
    end
  end

  logic word_msb;
  assign word_msb = word[47];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_msb_first;
    (active && new_half && frame_level == LEFT_LEVEL) |=> (line == $past(word_msb));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("left msb not sent first");

  property p_zero_tail;
    (active && bit_fall && !new_half && cnt == '0) |=> (line == 1'b0);
  endproperty
  a_zero_tail: assert property (p_zero_tail) else $error("bits past sample not zero");
endmodule

/* File: rtl/olmr_host.sv */
// host for one-line configs 1 and 2: programs routing and feeds the aux lines
`timescale 1ns/100ps
module olmr_host
  import olmr_pkg::*;
(
  input wire logic clk, // 40 MHz system clock
  input wire logic rst, // async reset, high
  input wire logic cfg_start, // pulse: program a configuration
  input wire logic cfg_two, // 0 config 1, 1 config 2
  input wire logic [1:0] cfg_speed, // speed code for both ports
  input wire logic [1:0] cfg_capture_ol, // capture one-line mode
  input wire logic [1:0] cfg_playback_ol, // playback one-line mode
  input wire logic [2:0] cfg_word_format, // word format field
  output logic cfg_busy, // register writes in progress
  output logic cfg_done, // configuration running
  output logic cfg_error, // last request refused
  output logic reg_wr_valid, // register write request
  input wire logic reg_wr_ready, // control port accepts write
  output logic [7:0] reg_wr_addr, // register offset
  output logic [7:0] reg_wr_data, // register value
  input wire logic smp_valid, // sample set offered
  output logic smp_ready, // sample holder empty
  input wire logic [23:0] smp_a_left, // line a left, slot 3
  input wire logic [23:0] smp_a_right, // line a right, slot 4
  input wire logic [23:0] smp_b_left, // line b left, slot 5
  input wire logic [23:0] smp_b_right, // line b right, slot 6
  input wire logic codec_bit_clock, // codec port bit clock pin
  input wire logic codec_frame_clock, // codec port frame clock pin
  input wire logic interface_bit_clock, // interface port bit clock pin
  input wire logic interface_frame_clock, // interface port frame clock pin
  output logic aux_converter_line_a, // aux serial line a
  output logic aux_converter_line_b // aux serial line b
);
  olmr_state_t state;
  olmr_state_t next_state;
  logic [7:0] next_addr;
  logic [7:0] next_data;
  logic next_error;
  logic two_q;
  logic next_two;
  logic [1:0] spd_q;
  logic [1:0] next_spd;
  logic [1:0] cap_q;
  logic [1:0] next_cap;
  logic [1:0] pb_q;
  logic [1:0] next_pb;
  logic [2:0] fmt_q;
  logic [2:0] next_fmt;
  logic req_ok;
  logic aux_active;

  function automatic logic combo_ok(input logic two, input logic [1:0] spd,
                                    input logic [1:0] cap, input logic [1:0] pb);
    logic ok;
    ok = 1'b1;
    if (spd == SPEED_QUAD || spd == 2'h3) ok = 1'b0;
    if (cap == OL_RESVD || pb == OL_RESVD) ok = 1'b0;
    if (!two) begin
      if (pb == OL_TWO && cap != OL_TWO) ok = 1'b0;
      if (cap == OL_TWO && pb == OL_ONE) ok = 1'b0;
      if ((cap == OL_TWO || pb == OL_TWO) && spd != SPEED_SINGLE) ok = 1'b0;
    end else begin
      if (pb == OL_TWO) ok = 1'b0;
      if (cap == OL_TWO && pb != OL_NONE) ok = 1'b0;
      if ((cap == OL_TWO || pb == OL_ONE) && spd != SPEED_SINGLE) ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic [7:0] mode_word(input logic two, input logic [1:0] spd);
    logic [7:0] d;
    d = '0;
    d[CODEC_FM_POS +: 2] = spd;
    d[IFACE_FM_POS +: 2] = spd;
    d[CAPSEL_POS +: 2] = two ? CAPSEL_IFACE : CAPSEL_CODEC;
    return d;
  endfunction

  function automatic logic [7:0] fmt_word(input logic [2:0] fmt, input logic [1:0] cap,
                                          input logic [1:0] pb);
    logic [7:0] d;
    d = '0;
    d[FMT_POS +: 3] = fmt;
    d[CAP_OL_POS +: 2] = cap;
    d[PB_OL_POS +: 2] = pb;
    return d;
  endfunction

  function automatic logic [7:0] misc_word(input logic two);
    logic [7:0] d;
    d = '0;
    d[CODEC_MS_BIT] = MASTER;
    d[IFACE_MS_BIT] = MASTER;
    d[EXT_CLKSEL_BIT] = two ? CLKSEL_CODEC : CLKSEL_IFACE;
    return d;
  endfunction

  assign req_ok = combo_ok(cfg_two, cfg_speed, cfg_capture_ol, cfg_playback_ol);

  always_comb begin
    next_state = state;
    next_addr = reg_wr_addr;
    next_data = reg_wr_data;
    next_error = cfg_error;
    next_two = two_q;
    next_spd = spd_q;
    next_cap = cap_q;
    next_pb = pb_q;
    next_fmt = fmt_q;
    unique case (state)
      ST_IDLE, ST_RUN: begin
        if (cfg_start) begin
          if (req_ok) begin
            next_error = 1'b0;
            next_two = cfg_two;
            next_spd = cfg_speed;
            next_cap = cfg_capture_ol;
            next_pb = cfg_playback_ol;
            next_fmt = cfg_word_format;
            next_state = ST_WR_MODE;
            next_addr = REG_SPEED_ROUTING;
            // one speed code on both ports keeps the frame clocks identical
            next_data = mode_word(cfg_two, cfg_speed);
          end else begin
            next_error = 1'b1;
          end
        end
      end
      ST_WR_MODE: begin
        if (reg_wr_ready) begin
          next_state = ST_WR_FMT;
          next_addr = REG_SERIAL_FORMAT;
          // device only honours the word format outside one-line mode
          next_data = fmt_word(fmt_q, cap_q, pb_q);
        end
      end
      ST_WR_FMT: begin
        if (reg_wr_ready) begin
          next_state = ST_WR_MISC;
          next_addr = REG_MASTER_CLKSEL;
          next_data = misc_word(two_q);
        end
      end
      ST_WR_MISC: begin
        if (reg_wr_ready) next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      reg_wr_addr <= '0;
      reg_wr_data <= '0;
      cfg_error <= 1'b0;
      two_q <= 1'b0;
      spd_q <= SPEED_SINGLE;
      cap_q <= OL_NONE;
      pb_q <= OL_NONE;
      fmt_q <= '0;
    end else begin
      state <= next_state;
      reg_wr_addr <= next_addr;
      reg_wr_data <= next_data;
      cfg_error <= next_error;
      two_q <= next_two;
      spd_q <= next_spd;
      cap_q <= next_cap;
      pb_q <= next_pb;
      fmt_q <= next_fmt;
    end
  end

  assign reg_wr_valid = (state == ST_WR_MODE) || (state == ST_WR_FMT) || (state == ST_WR_MISC);
  assign cfg_busy = reg_wr_valid;
  assign cfg_done = (state == ST_RUN);
  assign aux_active = (state == ST_RUN) && (cap_q != OL_NONE);

  // link pins: two flops each before any logic looks at them
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {codec_bit_clock, codec_frame_clock, interface_bit_clock, interface_frame_clock};
      pin_s2 <= pin_s1;
    end
  end

  logic sel_bclk;
  logic sel_lrck;
  logic bclk_prev;
  logic fall_d;
  logic next_fall_d;
  // the clock select written to the device also picks which port times the aux lines
  assign sel_bclk = (two_q == CLKSEL_CODEC) ? pin_s2[3] : pin_s2[1];
  assign sel_lrck = (two_q == CLKSEL_CODEC) ? pin_s2[2] : pin_s2[0];
  // act a cycle after the fall so a frame edge skewed by one sync cycle is still seen
  assign next_fall_d = bclk_prev && !sel_bclk;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bclk_prev <= 1'b0;
      fall_d <= 1'b0;
    end else begin
      bclk_prev <= sel_bclk;
      fall_d <= next_fall_d;
    end
  end

  // one-deep holder: an empty holder at a frame start sends silence
  logic [23:0] hold [0:3];
  logic [23:0] next_hold [0:3];
  logic full;
  logic next_full;
  logic [1:0] take;
  logic [1:0] line;
  logic [47:0] word [0:1];

  assign smp_ready = !full;

  always_comb begin
    next_full = full;
    for (int i = 0; i < 4; i++) next_hold[i] = hold[i];
    if (take[0]) next_full = 1'b0;
    if (smp_valid && !full) begin
      next_full = 1'b1;
      next_hold[0] = smp_a_left;
      next_hold[1] = smp_a_right;
      next_hold[2] = smp_b_left;
      next_hold[3] = smp_b_right;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      full <= 1'b0;
      for (int i = 0; i < 4; i++) hold[i] <= '0;
    end else begin
      full <= next_full;
      for (int i = 0; i < 4; i++) hold[i] <= next_hold[i];
    end
  end

  generate
    for (genvar g = 0; g < AUX_LINES; g++) begin : g_line
      // line a carries capture slots 3-4, line b slots 5-6
      assign word[g] = full ? {hold[2*g], hold[2*g+1]} : '0;
      olmr_aux_shifter u_shift (
        .clk(clk),
        .rst(rst),
        .bit_fall(fall_d),
        .frame_level(sel_lrck),
        .active(aux_active),
        .word(word[g]),
        .line(line[g]),
        .take(take[g])
      );
    end
  endgenerate

  assign aux_converter_line_a = line[0];
  assign aux_converter_line_b = line[1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_aux_idle;
    !aux_active |=> (!aux_converter_line_a && !aux_converter_line_b);
  endproperty
  a_aux_idle: assert property (p_aux_idle) else $error("aux line driven outside mode");

  property p_sel_cfg1;
    (state == ST_WR_MISC && !two_q) |-> (reg_wr_data[EXT_CLKSEL_BIT] == CLKSEL_IFACE);
  endproperty
  a_sel_cfg1: assert property (p_sel_cfg1) else $error("config 1 clock select wrong");

  property p_sel_cfg2;
    (state == ST_WR_MISC && two_q) |-> (reg_wr_data[EXT_CLKSEL_BIT] == CLKSEL_CODEC);
  endproperty
  a_sel_cfg2: assert property (p_sel_cfg2) else $error("config 2 clock select wrong");

  property p_masters;
    (state == ST_WR_MISC) |-> (reg_wr_data[CODEC_MS_BIT] && reg_wr_data[IFACE_MS_BIT]
                               && reg_wr_addr == REG_MASTER_CLKSEL);
  endproperty
  a_masters: assert property (p_masters) else $error("master bits not both set");

  property p_route;
    (state == ST_WR_MODE) |->
      (reg_wr_data[CAPSEL_POS +: 2] == (two_q ? CAPSEL_IFACE : CAPSEL_CODEC));
  endproperty
  a_route: assert property (p_route) else $error("capture port select wrong");

  property p_speed_eq;
    (state == ST_WR_MODE) |-> (reg_wr_data[CODEC_FM_POS +: 2] == reg_wr_data[IFACE_FM_POS +: 2]
                               && reg_wr_data[CODEC_FM_POS +: 2] != SPEED_QUAD);
  endproperty
  a_speed_eq: assert property (p_speed_eq) else $error("speed fields differ or quad");

  property p_pb_cfg2;
    (state == ST_WR_FMT && two_q) |-> (reg_wr_data[PB_OL_POS +: 2] != OL_TWO);
  endproperty
  a_pb_cfg2: assert property (p_pb_cfg2) else $error("config 2 playback mode 10");

  property p_refused;
    (cfg_start && !req_ok && (state == ST_IDLE || state == ST_RUN))
      |=> (cfg_error && !reg_wr_valid && state == $past(state));
  endproperty
  a_refused: assert property (p_refused) else $error("invalid combination accepted");

  property p_wr_hold;
    (reg_wr_valid && !reg_wr_ready) |=>
      (reg_wr_valid && $stable(reg_wr_addr) && $stable(reg_wr_data));
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request dropped early");

  c_cfg1: cover property ((state == ST_WR_MISC) && reg_wr_ready && !two_q);
  c_cfg2: cover property ((state == ST_WR_MISC) && reg_wr_ready && two_q);
  c_take: cover property (aux_active && take[0] && full);
endmodule

/* File: verification/olmr_dev_model.sv */
// device model: register file, master serial port clocks, aux line receiver
`timescale 1ns/100ps
module olmr_dev_model
  import olmr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic slow, // hold off after each write
  input wire logic reg_wr_valid, // write request
  output logic reg_wr_ready, // write taken
  input wire logic [7:0] reg_wr_addr, // offset
  input wire logic [7:0] reg_wr_data, // value
  output logic [7:0] mode_reg, // speed_and_port_routing
  output logic [7:0] fmt_reg, // serial_format_select
  output logic [7:0] misc_reg, // port_master_and_clock_select
  output logic codec_bit_clock, // 128 fs
  output logic codec_frame_clock, // high = left
  output logic interface_bit_clock, // 64 fs
  output logic interface_frame_clock, // high = left
  input wire logic aux_converter_line_a, // aux line a
  input wire logic aux_converter_line_b, // aux line b
  output logic [3:0][23:0] got, // slots 3 to 6
  output int frames // frames received
);
  logic [7:0] t = 8'h00;
  logic [4:0] cnt = 5'h00;
  logic last = 1'b0;
  logic [23:0] sh_a;
  logic [23:0] sh_b;
  logic bclk;
  logic fclk;

  initial got = '0;
  initial frames = 0;
  // master on both ports, so the clocks run free
  // codec bit clock period 200 ns, interface bit clock 400 ns
  always #100 t = t + 8'h01;
  assign codec_bit_clock = t[0];
  assign interface_bit_clock = t[1];
  assign codec_frame_clock = ~t[7];
  assign interface_frame_clock = ~t[7];
  assign bclk = misc_reg[EXT_CLKSEL_BIT] ? codec_bit_clock : interface_bit_clock;
  assign fclk = misc_reg[EXT_CLKSEL_BIT] ? codec_frame_clock : interface_frame_clock;

  // word format is fixed whatever the port registers hold
  always @(posedge bclk) begin
    if (fclk != last)
      cnt = 5'h00;
    last = fclk;
    if (cnt < 5'h18) begin
      sh_a = {sh_a[22:0], aux_converter_line_a};
      sh_b = {sh_b[22:0], aux_converter_line_b};
      cnt = cnt + 5'h01;
      if (cnt == 5'h18) begin
        got[last ? 0 : 1] = sh_a;
        got[last ? 2 : 3] = sh_b;
        if (!last)
          frames = frames + 1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr_ready <= 1'b0;
      mode_reg <= 8'h00;
      fmt_reg <= 8'h00;
      misc_reg <= 8'h00;
    end else begin
      // a slow control port drops ready for a cycle after each write
      reg_wr_ready <= !(slow && reg_wr_valid && reg_wr_ready);
      if (reg_wr_valid && reg_wr_ready) begin
        case (reg_wr_addr)
          REG_SPEED_ROUTING: mode_reg <= reg_wr_data;
          REG_SERIAL_FORMAT: fmt_reg <= reg_wr_data;
          REG_MASTER_CLKSEL: misc_reg <= reg_wr_data;
          default: ;
        endcase
      end
    end
  end
endmodule

/* File: verification/test_olmr_host.sv */
// self-checking bench for the one-line mode routing host
`timescale 1ns/100ps
module test_olmr_host;
  import olmr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_start = 1'b0;
  logic cfg_two = 1'b0;
  logic slow = 1'b0;
  logic smp_valid = 1'b0;
  logic [1:0] cfg_speed = 2'h0;
  logic [1:0] cfg_capture_ol = 2'h0;
  logic [1:0] cfg_playback_ol = 2'h0;
  logic [2:0] cfg_word_format = 3'h0;
  logic [3:0][23:0] smp = '0;
  logic [3:0][23:0] got;
  logic cfg_busy, cfg_done, cfg_error, reg_wr_valid, reg_wr_ready, smp_ready;
  logic [7:0] reg_wr_addr, reg_wr_data, mode_reg, fmt_reg, misc_reg;
  logic codec_bit_clock, codec_frame_clock, interface_bit_clock, interface_frame_clock;
  logic aux_converter_line_a, aux_converter_line_b;
  int frames;
  int wr_count = 0;
  int err_total = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;
  // writes really taken by the control port
  always @(posedge clk) if (reg_wr_valid && reg_wr_ready) wr_count++;

  olmr_host u_olmr_host (
    .clk(clk), .rst(rst), .cfg_start(cfg_start), .cfg_two(cfg_two), .cfg_speed(cfg_speed),
    .cfg_capture_ol(cfg_capture_ol), .cfg_playback_ol(cfg_playback_ol),
    .cfg_word_format(cfg_word_format), .cfg_busy(cfg_busy), .cfg_done(cfg_done),
    .cfg_error(cfg_error), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_a_left(smp[0]), .smp_a_right(smp[1]),
    .smp_b_left(smp[2]), .smp_b_right(smp[3]), .codec_bit_clock(codec_bit_clock),
    .codec_frame_clock(codec_frame_clock), .interface_bit_clock(interface_bit_clock),
    .interface_frame_clock(interface_frame_clock),
    .aux_converter_line_a(aux_converter_line_a), .aux_converter_line_b(aux_converter_line_b)
  );

  olmr_dev_model u_olmr_dev_model (
    .clk(clk), .rst(rst), .slow(slow), .reg_wr_valid(reg_wr_valid),
    .reg_wr_ready(reg_wr_ready), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .mode_reg(mode_reg), .fmt_reg(fmt_reg), .misc_reg(misc_reg),
    .codec_bit_clock(codec_bit_clock), .codec_frame_clock(codec_frame_clock),
    .interface_bit_clock(interface_bit_clock), .interface_frame_clock(interface_frame_clock),
    .aux_converter_line_a(aux_converter_line_a), .aux_converter_line_b(aux_converter_line_b),
    .got(got), .frames(frames)
  );

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic timeout;
    err_total++;
    $display("Error at %0t: wait expired, got %h expected %h", $time, 0, 1);
    end_of_test();
  endtask

  // c = {config two, speed, capture, playback, word format}
  task automatic configure(input logic [9:0] c, input logic ok);
    int w0;
    int i;
    w0 = wr_count;
    @(posedge clk);
    {cfg_two, cfg_speed, cfg_capture_ol, cfg_playback_ol, cfg_word_format} <= c;
    cfg_start <= 1'b1;
    @(posedge clk);
    cfg_start <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    for (i = 0; i < 40 && cfg_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 40)
      timeout();
    check(cfg_error, !ok);
    check(wr_count - w0, ok ? 3 : 0);
    check(cfg_done, 1'b1);
    if (ok) begin
      check(mode_reg[7:2], {c[8:7], c[8:7], c[9] ? CAPSEL_IFACE : CAPSEL_CODEC});
      check(fmt_reg[6:0], {c[2:0], c[6:5], c[4:3]});
      check(misc_reg[7:5], {MASTER, MASTER, c[9] ? CLKSEL_CODEC : CLKSEL_IFACE});
    end
  endtask

  task automatic wait_ready(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && smp_ready !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == lim)
      timeout();
  endtask

  task automatic wait_frame;
    int f0;
    int i;
    f0 = frames;
    for (i = 0; i < 3000 && frames == f0; i++)
      @(posedge clk);
    if (i == 3000)
      timeout();
  endtask

  task automatic t_stream(input logic two);
    logic [3:0][23:0] v;
    v = {24'hedcba9, 24'h123456, 24'h7ffffe, 24'h800001} ^ {96{two}};
    configure({two, 2'h0, 2'h1, two ? 2'h0 : 2'h1, 3'h0}, 1'b1);
    @(posedge clk);
    smp <= v;
    smp_valid <= 1'b1;
    wait_ready(1'b0, 8);
    @(posedge clk);
    smp_valid <= 1'b0;
    wait_ready(1'b1, 3000);
    wait_frame();
    for (int i = 0; i < 4; i++)
      check(got[i], v[i]);
    // nothing offered: the next frame carries zeros
    wait_frame();
    check(got[0], 24'h000000);
    $display("t_stream done");
  endtask

  task automatic t_config;
    logic [9:0] tbl [5] = '{10'b0_00_01_01_101, 10'b0_01_01_01_011, 10'b0_00_10_00_001,
                            10'b1_00_10_00_010, 10'b1_01_01_00_110};
    foreach (tbl[k]) begin
      slow <= k[0];
      configure(tbl[k], 1'b1);
    end
    $display("t_config done");
  endtask

  task automatic t_refuse;
    logic [9:0] tbl [5] = '{10'b0_10_01_01_000, 10'b0_00_11_00_000, 10'b1_00_01_10_000,
                            10'b0_01_10_00_000, 10'b1_00_10_01_000};
    foreach (tbl[k])
      configure(tbl[k], 1'b0);
    $display("t_refuse done");
  endtask

  task automatic t_idle;
    int bad = 0;
    configure(10'b0_00_00_01_000, 1'b1);
    for (int i = 0; i < 2500; i++) begin
      @(posedge clk);
      #1;
      if (aux_converter_line_a !== 1'b0 || aux_converter_line_b !== 1'b0)
        bad++;
    end
    check(bad, 0);
    $display("t_idle done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({cfg_busy, cfg_done, cfg_error, reg_wr_valid, smp_ready}, 5'h01);
    check({aux_converter_line_a, aux_converter_line_b}, 2'h0);
    $display("t_reset done");
    t_stream(1'b0);
    t_config();
    t_refuse();
    t_stream(1'b1);
    t_idle();
    end_of_test();
  end
endmodule
